// ---- core/orf_pkg.sv ----
// constants, types and register map shared by the overrange/sync block
// assumes a single sample clock and the plain register port of orf_top
package orf_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int SAMPLE_W = 8; // converter sample width, two's complement
  localparam int ADDR_W = 8; // register port address width
  localparam int DATA_W = 32; // register port data width
  localparam int NUM_FLAGS = 4; // two channels times two thresholds
  localparam int EV_W = 7; // number of interrupt events

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00; // sync-source select
  localparam logic [ADDR_W-1:0] ADDR_THR0 = 8'h04; // overrange_threshold0
  localparam logic [ADDR_W-1:0] ADDR_THR1 = 8'h08; // overrange_threshold1
  localparam logic [ADDR_W-1:0] ADDR_MINLEN = 8'h0c; // overrange_min_pulse_len
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10; // sticky events, write one to clear
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h14; // interrupt mask
  localparam logic [ADDR_W-1:0] ADDR_LIVE = 8'h18; // live state, read only

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_SEL_BIT = 0; // 0 single-ended pin, 1 differential pair
  localparam int EV_OVR_LSB = 0; // bits 3:0 rising edge of each flag
  localparam int EV_SYNC_REQ = 4; // link sync request seen (falling sync)
  localparam int EV_ILAS = 5; // alignment sequence started
  localparam int EV_PD = 6; // power-down pin went high
  localparam int LIVE_FLAG_LSB = 0; // bits 3:0 flag levels
  localparam int LIVE_SYNC = 4; // selected sync level
  localparam int LIVE_PD = 5; // synchronised power-down pin
  localparam int LIVE_CGS = 6; // lanes sending code groups
  localparam int LIVE_ILAS = 7; // lanes sending alignment sequence
  localparam int LIVE_DATA = 8; // lanes sending samples

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [SAMPLE_W-1:0] THR_RST = 8'hff; // never trips after reset
  localparam logic [SAMPLE_W-1:0] MINLEN_RST = 8'h01; // one sample minimum
  localparam logic [EV_W-1:0] MASK_RST = 7'h00; // all events masked
  localparam logic [2:0] PIN_IDLE = 3'h6; // sync pins idle high, power-down idle low

  // ****************************************
  // types
  // ****************************************
  // one register port access
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } orf_reg_req_t;

  // link progress toward the receiver
  typedef enum logic [1:0] {
    ST_WAIT,
    ST_CGS,
    ST_ILAS,
    ST_DATA
  } orf_link_st_t;

  // lane control toward the serializer
  typedef struct packed {
    logic lane_en;
    logic cgs;
    logic ilas;
    logic data;
  } orf_lane_ctl_t;

endpackage : orf_pkg

// ---- core/orf_sync2.sv ----
// two flip-flop level synchroniser for asynchronous pins
// assumes the pins are quasi-static relative to clk
module orf_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0 // idle level of each pin, held in reset
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // async in, synchronised out
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  import orf_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [W-1:0] meta; // first stage, read only by second stage
    logic [W-1:0] sync; // second stage, safe to use
  } orf_s2_t;

  orf_s2_t s_q;
  orf_s2_t s_d;

  // next state: shift the pin through two stages
  always_comb begin
    s_d.meta = pin;
    s_d.sync = s_q.meta;
  end

  // registers; both stages start at the idle level so no false edge follows reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= {RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.sync;

endmodule : orf_sync2

// ---- core/orf_ovr_flag.sv ----
// one fast overrange flag with minimum pulse hold
// assumes magnitude and threshold are from the same sample clock
module orf_ovr_flag #(
  parameter int MAG_W = 8,
  parameter int CNT_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // sample side
  input wire logic sample_valid,
  input wire logic [MAG_W-1:0] mag,
  input wire logic clear,
  // settings
  input wire logic [MAG_W-1:0] threshold,
  input wire logic [CNT_W-1:0] min_len,
  // flag pin
  output logic flag
);
  import orf_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic flag; // flag level
    logic [CNT_W-1:0] left; // samples still to hold
  } orf_ovr_t;

  orf_ovr_t s_q;
  orf_ovr_t s_d;
  logic exceed; // this sample is above threshold

  assign exceed = mag > threshold;

  // one evaluation per valid sample; zero length behaves as one
  always_comb begin
    s_d = s_q;
    if (clear) begin
      s_d = '0; // analog off, nothing to report
    end else if (sample_valid) begin
      if (exceed) begin
        s_d.flag = 1'b1;
        s_d.left = (min_len == '0) ? CNT_W'(1) : min_len;
      end else if (s_q.left > CNT_W'(1)) begin
        s_d.left = s_q.left - CNT_W'(1); // still inside the hold
      end else begin
        s_d.flag = 1'b0;
        s_d.left = '0;
      end
    end
  end

  // registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // samples seen since the flag rose, for the hold check
  logic [CNT_W:0] held_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      held_q <= '0;
    end else if (!s_q.flag) begin
      held_q <= '0;
    end else if (sample_valid && !(&held_q)) begin
      held_q <= held_q + (CNT_W + 1)'(1);
    end
  end

  a_flag_on_exceed: assert property (sample_valid && exceed && !clear |=> flag)
    else $error("flag did not rise on exceeding sample");
  a_flag_min_hold: assert property ($fell(flag) && !$past(clear)
      |-> held_q >= {1'b0, $past(min_len)})
    else $error("flag fell before minimum pulse length");
  a_flag_idle_drop: assert property (flag && sample_valid && !exceed && s_q.left <= CNT_W'(1)
      && !clear |=> !flag)
    else $error("flag held past its length");

endmodule : orf_ovr_flag

// ---- core/orf_top.sv ----
// overrange flags, link sync input and power-down pin logic
// assumes samples arrive on clk from the converter core; pins are asynchronous
// How it works
// - flag0 high while magnitude exceeds threshold0
// - flag1 high while magnitude exceeds threshold1
// - flags hold at least minimum pulse length unless power-down clears them
// - power-down pin disables analog and lanes
// - select zero takes sync from single pin
// - sync low starts and continues code groups
// - sync high after code groups starts alignment
// - select one takes sync from differential pair
module orf_top #(
  parameter int ILAS_LEN = 16, // cycles of alignment sequence
  parameter int CNT_W = 8 // minimum pulse counter width
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire orf_pkg::orf_reg_req_t reg_req,
  output logic [orf_pkg::DATA_W-1:0] reg_rdata,
  // sample stream from the converter core
  input wire logic sample_valid,
  input wire logic [orf_pkg::SAMPLE_W-1:0] chan_a_sample,
  input wire logic [orf_pkg::SAMPLE_W-1:0] chan_b_sample,
  // asynchronous pins
  input wire logic single_ended_sync_pin,
  input wire logic timestamp_diff_pair,
  input wire logic calib_power_down_pin,
  // overrange flag pins
  output logic chan_a_overrange_flag0,
  output logic chan_a_overrange_flag1,
  output logic chan_b_overrange_flag0,
  output logic chan_b_overrange_flag1,
  // serializer and analog control
  output orf_pkg::orf_lane_ctl_t lane_ctl,
  output logic analog_enable,
  // interrupt
  output logic irq
);
  import orf_pkg::*;

  localparam int ILW = $clog2(ILAS_LEN + 1); // alignment counter width

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic sel; // sync-source select
    logic [SAMPLE_W-1:0] thr0; // overrange_threshold0
    logic [SAMPLE_W-1:0] thr1; // overrange_threshold1
    logic [CNT_W-1:0] minlen; // overrange_min_pulse_len
    logic [EV_W-1:0] status; // sticky events
    logic [EV_W-1:0] mask; // interrupt enables
    logic [DATA_W-1:0] rdata; // read answer
    orf_link_st_t st; // link progress
    logic [ILW-1:0] ilas_left; // alignment cycles left
    orf_lane_ctl_t lane; // registered lane control
    logic analog_en; // registered analog enable
    logic [NUM_FLAGS-1:0] flags_prev; // for rising edge events
    logic sync_prev; // for falling sync event
    logic pd_prev; // for power-down event
  } orf_top_t;

  orf_top_t s_q;
  orf_top_t s_d;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic se_sync_s; // single-ended sync, synchronised
  logic ts_sync_s; // differential pair, synchronised
  logic pd_s; // power-down, synchronised

  orf_sync2 #(
    .W(3),
    .RST_VAL(PIN_IDLE) // active-low sync idles high, so reset is no request
  ) u_pins (
    .clk(clk),
    .resetn(resetn),
    .pin({single_ended_sync_pin, timestamp_diff_pair, calib_power_down_pin}),
    .level({se_sync_s, ts_sync_s, pd_s})
  );

  // active-low sync request from whichever pin is selected
  logic sync_lvl;
  assign sync_lvl = s_q.sel ? ts_sync_s : se_sync_s;
  // the unused single pin is expected grounded when the pair is used
  // it is simply ignored here, so a floating pin does no harm

  // ****************************************
  // overrange flags
  // ****************************************
  logic [SAMPLE_W-1:0] mag_a; // channel a magnitude
  logic [SAMPLE_W-1:0] mag_b; // channel b magnitude
  logic [NUM_FLAGS-1:0] flags; // a0, a1, b0, b1

  // absolute value; the most negative code maps to its unsigned magnitude
  always_comb begin
    mag_a = chan_a_sample[SAMPLE_W-1] ? SAMPLE_W'(-chan_a_sample) : chan_a_sample;
    mag_b = chan_b_sample[SAMPLE_W-1] ? SAMPLE_W'(-chan_b_sample) : chan_b_sample;
  end

  // one comparator per channel and threshold
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_ovr
      orf_ovr_flag #(
        .MAG_W(SAMPLE_W),
        .CNT_W(CNT_W)
      ) u_flag (
        .clk(clk),
        .resetn(resetn),
        .sample_valid(sample_valid),
        .mag((gi < 2) ? mag_a : mag_b),
        .clear(pd_s),
        .threshold((gi % 2 == 0) ? s_q.thr0 : s_q.thr1),
        .min_len(s_q.minlen),
        .flag(flags[gi])
      );
    end
  endgenerate

  assign chan_a_overrange_flag0 = flags[0];
  assign chan_a_overrange_flag1 = flags[1];
  assign chan_b_overrange_flag0 = flags[2];
  assign chan_b_overrange_flag1 = flags[3];

  // ****************************************
  // events
  // ****************************************
  logic [EV_W-1:0] events; // one-cycle event pulses
  logic wr_status; // write to status this cycle

  always_comb begin
    events = '0;
    events[EV_OVR_LSB +: NUM_FLAGS] = flags & ~s_q.flags_prev;
    events[EV_SYNC_REQ] = s_q.sync_prev & ~sync_lvl;
    events[EV_ILAS] = (s_q.st == ST_CGS) && !pd_s && sync_lvl; // no loop through s_d
    events[EV_PD] = pd_s & ~s_q.pd_prev;
  end

  assign wr_status = reg_req.wr && (reg_req.addr == ADDR_STATUS);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.flags_prev = flags;
    s_d.sync_prev = sync_lvl;
    s_d.pd_prev = pd_s;

    // register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_CTRL: s_d.sel = reg_req.wdata[CTRL_SEL_BIT];
        ADDR_THR0: s_d.thr0 = reg_req.wdata[SAMPLE_W-1:0];
        ADDR_THR1: s_d.thr1 = reg_req.wdata[SAMPLE_W-1:0];
        ADDR_MINLEN: s_d.minlen = reg_req.wdata[CNT_W-1:0];
        ADDR_MASK: s_d.mask = reg_req.wdata[EV_W-1:0];
        default: s_d.sel = s_q.sel; // status handled below, others ignored
      endcase
    end

    // link progress toward the receiver
    s_d.ilas_left = s_q.ilas_left;
    if (pd_s) begin
      s_d.st = ST_WAIT;
    end else if (!sync_lvl) begin
      s_d.st = ST_CGS;
    end else begin
      case (s_q.st)
        ST_WAIT: s_d.st = ST_WAIT; // nothing until a request
        ST_CGS: begin
          s_d.st = ST_ILAS;
          s_d.ilas_left = ILW'(ILAS_LEN);
        end
        ST_ILAS: begin
          if (s_q.ilas_left <= ILW'(1)) begin
            s_d.st = ST_DATA;
            s_d.ilas_left = '0;
          end else begin
            s_d.ilas_left = s_q.ilas_left - ILW'(1);
          end
        end
        ST_DATA: s_d.st = ST_DATA;
        default: s_d.st = ST_WAIT;
      endcase
    end

    // lane and analog control follow the next state
    s_d.lane.lane_en = !pd_s;
    s_d.lane.cgs = (s_d.st == ST_CGS);
    s_d.lane.ilas = (s_d.st == ST_ILAS);
    s_d.lane.data = (s_d.st == ST_DATA);
    s_d.analog_en = !pd_s;

    // sticky status: a new event wins over a clear in the same cycle
    s_d.status = (s_q.status & ~(wr_status ? reg_req.wdata[EV_W-1:0] : '0)) | events;

    // read answer, standing for the cycle after the strobe only
    s_d.rdata = '0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_CTRL: s_d.rdata[CTRL_SEL_BIT] = s_q.sel;
        ADDR_THR0: s_d.rdata[SAMPLE_W-1:0] = s_q.thr0;
        ADDR_THR1: s_d.rdata[SAMPLE_W-1:0] = s_q.thr1;
        ADDR_MINLEN: s_d.rdata[CNT_W-1:0] = s_q.minlen;
        ADDR_STATUS: s_d.rdata[EV_W-1:0] = s_q.status;
        ADDR_MASK: s_d.rdata[EV_W-1:0] = s_q.mask;
        ADDR_LIVE: begin
          s_d.rdata[LIVE_FLAG_LSB +: NUM_FLAGS] = flags;
          s_d.rdata[LIVE_SYNC] = sync_lvl;
          s_d.rdata[LIVE_PD] = pd_s;
          s_d.rdata[LIVE_CGS] = s_q.lane.cgs;
          s_d.rdata[LIVE_ILAS] = s_q.lane.ilas;
          s_d.rdata[LIVE_DATA] = s_q.lane.data;
        end
        default: s_d.rdata = '0; // unmapped reads as zero
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // reset leaves lanes off for one clock only; the first clock enables them from the synchroniser idle level, before the pins reach pd_s
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q.sel <= 1'b0;
      s_q.thr0 <= THR_RST;
      s_q.thr1 <= THR_RST;
      s_q.minlen <= CNT_W'(MINLEN_RST);
      s_q.status <= '0;
      s_q.mask <= MASK_RST;
      s_q.rdata <= '0;
      s_q.st <= ST_WAIT;
      s_q.ilas_left <= '0;
      s_q.lane <= '0;
      s_q.analog_en <= 1'b0;
      s_q.flags_prev <= '0;
      s_q.sync_prev <= 1'b1; // sync idles high
      s_q.pd_prev <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = s_q.rdata;
  assign lane_ctl = s_q.lane;
  assign analog_enable = s_q.analog_en;
  assign irq = |(s_q.status & s_q.mask); // level, not a pulse

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // receiver releases sync after code groups
  sequence s_cgs_release;
    !pd_s && sync_lvl && s_q.st == ST_CGS;
  endsequence

  // alignment then shows on the lanes in the next cycle, with code groups stopped
  sequence s_ilas_run;
    lane_ctl.ilas && !lane_ctl.cgs;
  endsequence

  a_pd_lanes_off: assert property (pd_s |=> !lane_ctl.lane_en && !analog_enable)
    else $error("lanes or analog on during power-down");
  a_pd_flags_low: assert property (pd_s |=> flags == '0)
    else $error("flags active during power-down");
  a_cgs_on_low: assert property (!pd_s && !sync_lvl |=> lane_ctl.cgs && s_q.st == ST_CGS)
    else $error("no code groups while sync low");
  a_ilas_start: assert property (s_cgs_release |=> s_ilas_run)
    else $error("alignment did not follow sync release");
  a_sel0_source: assert property (!s_q.sel && !pd_s && $fell(se_sync_s)
      |=> s_q.st == ST_CGS)
    else $error("single pin sync not honoured");
  a_sel1_source: assert property (s_q.sel && !pd_s && !ts_sync_s
      |=> s_q.st == ST_CGS)
    else $error("differential sync not honoured");
  a_status_set_wins: assert property (events[EV_SYNC_REQ] |=> s_q.status[EV_SYNC_REQ])
    else $error("event lost against clear");
  a_irq_follows: assert property (|(events & s_q.mask) && !reg_req.wr |=> irq)
    else $error("unmasked event did not raise interrupt");
  a_flag_cause: assert property ($rose(flags[0]) |-> $past(sample_valid)
      && $past(mag_a > s_q.thr0))
    else $error("flag rose without exceeding sample");

endmodule : orf_top

// ---- verification/orf_rx_model.sv ----
// behavioural link receiver that drives the active-low sync request
// assumes the block's lane control outputs and one shared sample clock
module orf_rx_model #(
  parameter int HOLD = 4 // code group cycles seen before release
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // lane state from the transmitter
  input wire orf_pkg::orf_lane_ctl_t lane_ctl,
  // bench controls
  input wire logic use_pair,
  input wire logic start,
  // sync pins
  output logic single_ended_sync_pin,
  output logic timestamp_diff_pair
);
  timeunit 1ns;
  timeprecision 1ps;
  import orf_pkg::*;

  logic sync_n_q; // active-low request level
  int cnt_q; // code group cycles counted

  // ****************************************
  // request on start, release once code groups were seen
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_n_q <= 1'b1;
      cnt_q <= 0;
    end else if (start) begin
      // request resync, held low while lanes send code groups
      sync_n_q <= 1'b0;
      cnt_q <= 0;
    end else if (!sync_n_q && lane_ctl.cgs) begin
      cnt_q <= cnt_q + 1;
      // release high after enough code groups
      if (cnt_q >= HOLD - 1) begin
        sync_n_q <= 1'b1;
      end
    end
  end

  // single pin grounded whenever the pair carries the request
  assign single_ended_sync_pin = use_pair ? 1'b0 : sync_n_q;
  // idle pair stands high, no request
  assign timestamp_diff_pair = use_pair ? sync_n_q : 1'b1;
endmodule : orf_rx_model

// ---- verification/orf_top_tb.sv ----
// self-checking bench for the overrange flag and link sync block
// assumes orf_top with a short alignment length and the receiver model
module orf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import orf_pkg::*;

  localparam int ILAS_N = 4; // shortened alignment length

  logic clk;
  logic resetn;
  orf_reg_req_t reg_req;
  logic [DATA_W-1:0] reg_rdata;
  logic sample_valid;
  logic [SAMPLE_W-1:0] a_smp, b_smp;
  logic se_pin, pair_pin, pd_pin, use_pair, start;
  logic fa0, fa1, fb0, fb1, analog_enable, irq;
  orf_lane_ctl_t lane_ctl;
  int n_mismatch = 0;
  int checked = 0;

  orf_top #(.ILAS_LEN(ILAS_N), .CNT_W(8)) u_dut (
    .clk(clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sample_valid(sample_valid), .chan_a_sample(a_smp), .chan_b_sample(b_smp),
    .single_ended_sync_pin(se_pin), .timestamp_diff_pair(pair_pin),
    .calib_power_down_pin(pd_pin), .chan_a_overrange_flag0(fa0),
    .chan_a_overrange_flag1(fa1), .chan_b_overrange_flag0(fb0),
    .chan_b_overrange_flag1(fb1), .lane_ctl(lane_ctl),
    .analog_enable(analog_enable), .irq(irq));

  orf_rx_model #(.HOLD(3)) u_rx (
    .clk(clk), .resetn(resetn), .lane_ctl(lane_ctl), .use_pair(use_pair),
    .start(start), .single_ended_sync_pin(se_pin), .timestamp_diff_pair(pair_pin));

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask : reg_wr

  // read answer is looked at mid-cycle, the only cycle it stands
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : reg_rd

  // one valid sample per channel, flags read the cycle after
  task automatic smp(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    sample_valid <= 1'b1;
    a_smp <= a;
    b_smp <= b;
    @(posedge clk);
    sample_valid <= 1'b0;
    @(negedge clk);
  endtask : smp

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] d;
    reg_rd(ADDR_THR0, d);
    chk(d, 32'h0000_00ff);
    reg_rd(ADDR_MINLEN, d);
    chk(d, 32'h0000_0001);
    reg_rd(ADDR_MASK, d);
    chk(d, 32'h0);
    reg_rd(8'h1c, d); // unmapped place reads zero
    chk(d, 32'h0);
    chk({31'h0, analog_enable}, 32'h1);
  endtask : t_regs

  task automatic t_flags();
    reg_wr(ADDR_THR0, 32'h40);
    reg_wr(ADDR_THR1, 32'h60);
    reg_wr(ADDR_MINLEN, 32'h3);
    smp(8'h41, 8'h40); // one above, one equal
    chk({fa0, fa1, fb0, fb1}, 4'b1000);
    repeat (3) smp(8'h00, 8'h00);
    smp(8'h9f, 8'h80); // minus 97 and minus 128
    chk({fa0, fa1, fb0, fb1}, 4'b1111);
    repeat (10) @(posedge clk); // idle cycles do not shorten the pulse
    repeat (2) smp(8'h00, 8'h00);
    chk({fa0, fa1, fb0, fb1}, 4'b1111);
    repeat (2) smp(8'h00, 8'h00);
    chk({fa0, fa1, fb0, fb1}, 4'b0000);
  endtask : t_flags

  task automatic t_irq();
    logic [31:0] d;
    reg_rd(ADDR_STATUS, d);
    chk(d & 32'hf, 32'hf);
    chk({31'h0, irq}, 32'h0);
    reg_wr(ADDR_MASK, 32'h1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    reg_wr(ADDR_STATUS, 32'h1);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    reg_rd(ADDR_STATUS, d);
    chk(d & 32'hf, 32'he);
  endtask : t_irq

  // full link bring-up through the selected sync source
  task automatic t_sync(input logic sel);
    logic [31:0] d;
    int n;
    reg_wr(ADDR_CTRL, {31'h0, sel});
    @(posedge clk);
    use_pair <= sel;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk({31'h0, lane_ctl.cgs}, 32'h0);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    while (!lane_ctl.cgs && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, lane_ctl.cgs}, 32'h1);
    n = 0;
    while (!lane_ctl.ilas && n < 30) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (lane_ctl.ilas && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk(n, ILAS_N);
    chk({31'h0, lane_ctl.data}, 32'h1);
    reg_rd(ADDR_LIVE, d); // sync level high, lanes sending samples
    chk(d, 32'h0000_0110);
    reg_rd(ADDR_STATUS, d);
    chk(d & 32'h30, 32'h30);
    reg_wr(ADDR_STATUS, 32'h7f);
  endtask : t_sync

  task automatic t_pd();
    logic [31:0] d;
    reg_wr(ADDR_MASK, 32'h40); // only the power-down event may interrupt
    @(posedge clk);
    pd_pin <= 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({analog_enable, lane_ctl}, 5'h0);
    chk({31'h0, irq}, 32'h1);
    reg_rd(ADDR_STATUS, d);
    chk(d & 32'h40, 32'h40);
    reg_wr(ADDR_STATUS, 32'h40);
    @(posedge clk);
    pd_pin <= 1'b0; // normal operation keeps it low
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({29'h0, analog_enable, lane_ctl.lane_en, irq}, 32'h6);
  endtask : t_pd

  // ****************************************
  // verdict, clock, watchdog and main sequence
  // ****************************************
  task automatic complete_run();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // whole run is well under 1000 cycles
  initial begin
    #(40 * 5000);
    n_mismatch++;
    complete_run();
  end

  initial begin
    resetn = 1'b0;
    reg_req = '0;
    sample_valid = 1'b0;
    a_smp = 8'h00;
    b_smp = 8'h00;
    pd_pin = 1'b0;
    use_pair = 1'b0;
    start = 1'b0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_flags();
    t_irq();
    t_sync(1'b0);
    t_sync(1'b1);
    t_pd();
    complete_run();
  end
endmodule : orf_top_tb
